// >>> hpb_downstream_cfg.sv
`include "hpb_map.svh"
module hpb_downstream_cfg (
   // clock and reset
   input wire logic i_mclk,
   input wire logic i_rst,
   // configuration register access
   input wire logic i_cfg_wr,
   input wire logic i_cfg_rd,
   input wire logic [7:0] i_cfg_addr,
   input wire logic [7:0] i_cfg_wdata,
   output logic [7:0] o_cfg_rdata,
   output logic o_cfg_rvalid,
   // configuration request from hub side
   input wire logic i_cfgreq_valid,
   input wire logic [7:0] i_cfgreq_bus,
   output logic o_cfg_type1,
   output logic o_cfg_mabort,
   // pci master tenure
   input wire logic i_frame_start,
   input wire logic i_burst_active,
   input wire logic i_gnt_int,
   output logic o_end_burst,
   // i/o window decode
   input wire logic i_io_valid,
   input wire logic [15:0] i_io_addr,
   output logic o_io_hit,
   // error events
   input wire hpb_pkg::hpb_err_evt_t i_evt,
   input wire logic i_parity_resp_en,
   output logic o_upstream_sta_set,
   output logic o_tabort_to_hub
);
   import hpb_pkg::*;

   // ==========================================
   // registers
   logic [7:0] dbn_ff;
   logic [7:0] hbn_ff;
   logic [4:0] btt_ff;
   logic [3:0] iob_ff;
   logic [3:0] iol_ff;
   logic dpe_ff;
   logic sse_ff;
   logic rma_ff;
   logic rta_ff;
   logic master_parity_fault_flag_ff;
   logic [7:0] tenure_counter_ff;
   logic [7:0] nxt_tenure_counter;
   hpb_ten_state_t ten_state_ff;
   hpb_ten_state_t nxt_ten_state;
   logic [7:0] nxt_rdata;
   logic [15:0] io_lo;
   logic [15:0] io_hi;
   logic wr_stl;
   logic wr_sth;
   logic master_parity_fault_flag_evt;

   assign wr_stl = i_cfg_wr && (i_cfg_addr == `HPB_OFS_STL);
   assign wr_sth = i_cfg_wr && (i_cfg_addr == `HPB_OFS_STH);

   // ==========================================
   // bus numbers
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         dbn_ff <= `HPB_RST_DBN;
         hbn_ff <= `HPB_RST_HBN;
      end else if (i_cfg_wr) begin
         if (i_cfg_addr == `HPB_OFS_DBN) begin
            dbn_ff <= i_cfg_wdata;
         end
         if (i_cfg_addr == `HPB_OFS_HBN) begin
            hbn_ff <= i_cfg_wdata;
         end
      end
   end

   // ==========================================
   // tenure and i/o window fields; reserved bits are not stored at all
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         btt_ff <= 5'(`HPB_RST_BTT >> `HPB_BTT_LSB);
         iob_ff <= 4'(`HPB_RST_IOB >> `HPB_IO_LSB);
         iol_ff <= 4'(`HPB_RST_IOL >> `HPB_IO_LSB);
      end else if (i_cfg_wr) begin
         if (i_cfg_addr == `HPB_OFS_BTT) begin
            btt_ff <= i_cfg_wdata[`HPB_BTT_MSB:`HPB_BTT_LSB];
         end
         if (i_cfg_addr == `HPB_OFS_IOB) begin
            iob_ff <= i_cfg_wdata[`HPB_IO_MSB:`HPB_IO_LSB];
         end
         if (i_cfg_addr == `HPB_OFS_IOL) begin
            iol_ff <= i_cfg_wdata[`HPB_IO_MSB:`HPB_IO_LSB];
         end
      end
   end

   // ==========================================
   // status flags: a new event wins over a clear in the same cycle
   assign master_parity_fault_flag_evt = i_parity_resp_en && i_evt.int_master &&
                     (i_evt.perr_on_write || i_evt.rd_parity_fail);

   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         dpe_ff <= 1'(`HPB_RST_STS >> `HPB_ST_DPE);
         sse_ff <= 1'b0;
         rma_ff <= 1'b0;
         rta_ff <= 1'b0;
         master_parity_fault_flag_ff <= 1'b0;
      end else begin
         // bit index minus 8 selects the lane of the high byte
         if (i_evt.parity_err) begin
            dpe_ff <= 1'b1;
         end else if (wr_sth && i_cfg_wdata[`HPB_ST_DPE-8]) begin
            dpe_ff <= 1'b0;
         end
         if (i_evt.serr_seen) begin
            sse_ff <= 1'b1;
         end else if (wr_sth && i_cfg_wdata[`HPB_ST_SSE-8]) begin
            sse_ff <= 1'b0;
         end
         if (i_evt.fwd_mabort) begin
            rma_ff <= 1'b1;
         end else if (wr_sth && i_cfg_wdata[`HPB_ST_RMA-8]) begin
            rma_ff <= 1'b0;
         end
         if (i_evt.fwd_tabort) begin
            rta_ff <= 1'b1;
         end else if (wr_sth && i_cfg_wdata[`HPB_ST_RTA-8]) begin
            rta_ff <= 1'b0;
         end
         if (master_parity_fault_flag_evt) begin
            master_parity_fault_flag_ff <= 1'b1;
         end else if (wr_sth && i_cfg_wdata[`HPB_ST_MASTER_PARITY_FAULT_FLAG-8]) begin
            master_parity_fault_flag_ff <= 1'b0;
         end
      end
   end

   // ==========================================
   // target abort reporting toward the hub side
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         o_upstream_sta_set <= 1'b0;
         o_tabort_to_hub <= 1'b0;
      end else begin
         // only completion-required cycles have someone waiting for status
         o_upstream_sta_set <= i_evt.fwd_tabort && i_evt.fwd_tabort_cpl;
         o_tabort_to_hub <= i_evt.fwd_tabort && i_evt.fwd_tabort_cpl;
      end
   end

   // ==========================================
   // read mux; unmapped offsets, including the upper i/o words, read zero
   always_comb begin
      nxt_rdata = 8'h00;
      case (i_cfg_addr)
         `HPB_OFS_DBN: nxt_rdata = dbn_ff;
         `HPB_OFS_HBN: nxt_rdata = hbn_ff;
         `HPB_OFS_BTT: nxt_rdata = {btt_ff, 3'h0};
         `HPB_OFS_IOB: nxt_rdata = {iob_ff, 4'h0};
         `HPB_OFS_IOL: nxt_rdata = {iol_ff, 4'h0};
         `HPB_OFS_STL: nxt_rdata = {`HPB_ST_FBB, 7'h00};
         `HPB_OFS_STH: nxt_rdata = {dpe_ff, sse_ff, rma_ff, rta_ff,
                                    1'b0, `HPB_ST_TIMING, master_parity_fault_flag_ff};
         default: nxt_rdata = 8'h00;
      endcase
   end

   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         o_cfg_rdata <= 8'h00;
         o_cfg_rvalid <= 1'b0;
      end else begin
         o_cfg_rvalid <= i_cfg_rd;
         if (i_cfg_rd) begin
            o_cfg_rdata <= nxt_rdata;
         end
      end
   end

   // ==========================================
   // configuration forwarding decision
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         o_cfg_type1 <= 1'b0;
         o_cfg_mabort <= 1'b0;
      end else if (i_cfgreq_valid) begin
         // equal to primary bus zero always goes out, even if highest is stale
         if ((i_cfgreq_bus == dbn_ff && dbn_ff == `HPB_PRIMARY_BUS) ||
             (i_cfgreq_bus >= dbn_ff && i_cfgreq_bus <= hbn_ff)) begin
            o_cfg_type1 <= 1'b1;
            o_cfg_mabort <= 1'b0;
         end else begin
            o_cfg_type1 <= 1'b0;
            o_cfg_mabort <= 1'b1;
         end
      end else begin
         o_cfg_type1 <= 1'b0;
         o_cfg_mabort <= 1'b0;
      end
   end

   // ==========================================
   // burst tenure counter
   always_comb begin
      nxt_ten_state = ten_state_ff;
      nxt_tenure_counter = tenure_counter_ff;
      case (ten_state_ff)
         TEN_IDLE: begin
            if (i_frame_start) begin
               nxt_ten_state = TEN_COUNT;
               nxt_tenure_counter = {btt_ff, 3'h0};
            end
         end
         TEN_COUNT: begin
            if (!i_burst_active) begin
               nxt_ten_state = TEN_IDLE;
            end else if (tenure_counter_ff == 8'h00) begin
               nxt_ten_state = TEN_EXPIRED;
            end else begin
               nxt_tenure_counter = tenure_counter_ff - 8'h01;
            end
         end
         TEN_EXPIRED: begin
            // stays here while the burst is active; the grant only holds off o_end_burst, so the burst may run on
            if (!i_burst_active) begin
               nxt_ten_state = TEN_IDLE;
            end
         end
         default: nxt_ten_state = TEN_IDLE;
      endcase
   end

   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         ten_state_ff <= TEN_IDLE;
         tenure_counter_ff <= 8'h00;
      end else begin
         ten_state_ff <= nxt_ten_state;
         tenure_counter_ff <= nxt_tenure_counter;
      end
   end

   // end-of-burst request to the frame logic
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         o_end_burst <= 1'b0;
      end else begin
         o_end_burst <= (ten_state_ff == TEN_EXPIRED) && i_burst_active &&
                        !i_gnt_int;
      end
   end

   // ==========================================
   // i/o window decode
   assign io_lo = {iob_ff, `HPB_IO_LOW_BASE};
   assign io_hi = {iol_ff, `HPB_IO_LOW_LIM};

   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         o_io_hit <= 1'b0;
      end else begin
         o_io_hit <= i_io_valid && (i_io_addr >= io_lo) &&
                     (i_io_addr <= io_hi);
      end
   end

   // ==========================================
   // assertions
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_rst);

   sequence s_frame_load;
      (ten_state_ff == TEN_IDLE) && i_frame_start;
   endsequence

   sequence s_expired_no_gnt;
      (ten_state_ff == TEN_EXPIRED) && i_burst_active && !i_gnt_int;
   endsequence

   AST_TENURE_LOAD: assert property (s_frame_load |=>
      tenure_counter_ff == {$past(btt_ff), 3'h0})
      else $error("tenure counter not loaded at frame start");
   AST_TENURE_END: assert property (s_expired_no_gnt |=> o_end_burst)
      else $error("burst not ended after expiry without grant");
   AST_TENURE_KEEP: assert property (i_gnt_int |=> !o_end_burst)
      else $error("burst ended while grant present");
   AST_MABORT: assert property (i_cfgreq_valid &&
      (i_cfgreq_bus > hbn_ff) && (i_cfgreq_bus != `HPB_PRIMARY_BUS) |=> o_cfg_mabort)
      else $error("out of range request not master-aborted");
   AST_TYPE1_BUS0: assert property (i_cfgreq_valid &&
      dbn_ff == 8'h00 && i_cfgreq_bus == 8'h00 |=> o_cfg_type1 && !o_cfg_mabort)
      else $error("bus zero request not forwarded");
   AST_DPE_SET: assert property (i_evt.parity_err |=> dpe_ff)
      else $error("parity flag not set");
   AST_SSE_SET: assert property (i_evt.serr_seen |=> sse_ff)
      else $error("system error flag not set");
   AST_RMA_SET: assert property (i_evt.fwd_mabort |=> rma_ff)
      else $error("master abort flag not set");
   AST_RTA_SET: assert property (i_evt.fwd_tabort |=> rta_ff)
      else $error("target abort flag not set");
   AST_W1C: assert property (wr_sth && i_cfg_wdata[5] && !i_evt.fwd_mabort
      |=> !rma_ff)
      else $error("write one did not clear flag");
   AST_MASTER_PARITY_FAULT_FLAG_GATE: assert property (!i_parity_resp_en && !master_parity_fault_flag_ff |=> !master_parity_fault_flag_ff)
      else $error("parity fault flag set without enable");
   AST_STS_CONST: assert property (i_cfg_rd && i_cfg_addr == `HPB_OFS_STH
      |=> o_cfg_rvalid && o_cfg_rdata[3:1] == 3'b001)
      else $error("fixed status bits wrong");
   AST_FBB_READ: assert property (i_cfg_rd && i_cfg_addr == `HPB_OFS_STL
      |=> o_cfg_rdata == 8'h80)
      else $error("low status byte wrong");
   AST_IO_HIT: assert property (i_io_valid && i_io_addr[15:12] >= iob_ff &&
      i_io_addr[15:12] <= iol_ff |=> o_io_hit)
      else $error("window address not claimed");
   AST_STA_REPORT: assert property (i_evt.fwd_tabort && i_evt.fwd_tabort_cpl
      |=> o_upstream_sta_set && o_tabort_to_hub)
      else $error("target abort not reported upstream");
endmodule : hpb_downstream_cfg

// >>> hpb_map.svh
`ifndef HPB_MAP_SVH
`define HPB_MAP_SVH
// ==========================================
// configuration offsets (byte addresses)
`define HPB_OFS_DBN 8'h19
`define HPB_OFS_HBN 8'h1a
`define HPB_OFS_BTT 8'h1b
`define HPB_OFS_IOB 8'h1c
`define HPB_OFS_IOL 8'h1d
`define HPB_OFS_STL 8'h1e
`define HPB_OFS_STH 8'h1f
// ==========================================
// reset values
`define HPB_RST_DBN 8'h00
`define HPB_RST_HBN 8'h00
`define HPB_RST_BTT 8'h00
`define HPB_RST_IOB 8'hf0
`define HPB_RST_IOL 8'h00
`define HPB_RST_STS 16'h0280
// ==========================================
// field positions and constants
`define HPB_BTT_MSB 7
`define HPB_BTT_LSB 3
`define HPB_IO_MSB 7
`define HPB_IO_LSB 4
`define HPB_IO_LOW_BASE 12'h000
`define HPB_IO_LOW_LIM 12'hfff
`define HPB_PRIMARY_BUS 8'h00
`define HPB_ST_DPE 15
`define HPB_ST_SSE 14
`define HPB_ST_RMA 13
`define HPB_ST_RTA 12
`define HPB_ST_STA 11
`define HPB_ST_MASTER_PARITY_FAULT_FLAG 8
`define HPB_ST_TIMING 2'b01
`define HPB_ST_FBB 1'b1
`define HPB_TENURE_UNIT 3
`endif

// >>> hpb_pci_agent.sv
module hpb_pci_agent (
   // clock
   input wire logic i_mclk,
   // tenure verdict from the bridge
   input wire logic i_end_burst,
   // master and error activity on the pci side
   output logic o_frame_start,
   output logic o_burst_active,
   output logic o_gnt_int,
   output hpb_pkg::hpb_err_evt_t o_evt,
   output logic o_parity_resp_en
);
   timeunit 1ns;
   timeprecision 1ps;
   import hpb_pkg::*;

   // quiet bus until a task starts activity
   initial begin
      o_frame_start = 1'b0;
      o_burst_active = 1'b0;
      o_gnt_int = 1'b0;
      o_evt = '0;
      o_parity_resp_en = 1'b0;
   end

   // our master lets go of frame at the falling edge half a clock after the bridge calls time, so a stuck end shows up
   always @(negedge i_mclk) begin
      if (i_end_burst) begin
         o_burst_active <= 1'b0;
      end
   end

   // ==========================================
   // activity tasks, all driven off the falling edge
   task automatic start_burst(input logic gnt);
      @(negedge i_mclk);
      o_frame_start = 1'b1;
      o_burst_active = 1'b1;
      o_gnt_int = gnt;
      @(negedge i_mclk);
      o_frame_start = 1'b0;
   endtask : start_burst

   task automatic set_gnt(input logic gnt);
      @(negedge i_mclk);
      o_gnt_int = gnt;
   endtask : set_gnt

   // one-cycle event pulse; parity response level stays until changed
   task automatic fire(input hpb_err_evt_t e, input logic pre);
      @(negedge i_mclk);
      o_evt = e;
      o_parity_resp_en = pre;
      @(negedge i_mclk);
      o_evt = '0;
   endtask : fire
endmodule : hpb_pci_agent

// >>> hpb_pkg.sv
package hpb_pkg;
   // ==========================================
   // error events seen on the pci side
   typedef struct packed {
      logic parity_err;
      logic serr_seen;
      logic fwd_mabort;
      logic fwd_tabort;
      logic fwd_tabort_cpl;
      logic int_master;
      logic perr_on_write;
      logic rd_parity_fail;
   } hpb_err_evt_t;

   // ==========================================
   // tenure counter states
   typedef enum logic [2:0] {
      TEN_IDLE = 3'b001,
      TEN_COUNT = 3'b010,
      TEN_EXPIRED = 3'b100
   } hpb_ten_state_t;
endpackage : hpb_pkg

// >>> tb_top.sv
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin miscompares++; $display("Error %s expected %h seen %h", nm, e, g); end end

module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import hpb_pkg::*;

   logic i_mclk, i_rst, i_cfg_wr, i_cfg_rd, i_cfgreq_valid, i_io_valid;
   logic i_frame_start, i_burst_active, i_gnt_int, i_parity_resp_en;
   logic [7:0] i_cfg_addr, i_cfg_wdata, i_cfgreq_bus, o_cfg_rdata;
   logic [15:0] i_io_addr;
   hpb_err_evt_t i_evt;
   logic o_cfg_rvalid, o_cfg_type1, o_cfg_mabort, o_end_burst, o_io_hit, o_upstream_sta_set, o_tabort_to_hub;
   int miscompares = 0;
   int checked = 0;
   int cycles = 0;
   logic [7:0] wa[8] = '{8'h19, 8'h1a, 8'h1b, 8'h1c, 8'h1d, 8'h1e, 8'h1f, 8'h30};
   logic [7:0] rst_exp[7] = '{8'h00, 8'h00, 8'h00, 8'hf0, 8'h00, 8'h80, 8'h02};
   logic [7:0] wr_exp[8] = '{8'hff, 8'hff, 8'hf8, 8'hf0, 8'hf0, 8'h80, 8'h02, 8'h00};
   hpb_err_evt_t ev[4] = '{8'h80, 8'h40, 8'h20, 8'h10};

   hpb_downstream_cfg hpb_downstream_cfg_i (.i_mclk, .i_rst, .i_cfg_wr, .i_cfg_rd, .i_cfg_addr, .i_cfg_wdata,
      .o_cfg_rdata, .o_cfg_rvalid, .i_cfgreq_valid, .i_cfgreq_bus, .o_cfg_type1, .o_cfg_mabort,
      .i_frame_start, .i_burst_active, .i_gnt_int, .o_end_burst, .i_io_valid, .i_io_addr, .o_io_hit,
      .i_evt, .i_parity_resp_en, .o_upstream_sta_set, .o_tabort_to_hub);

   hpb_pci_agent hpb_pci_agent_i (.i_mclk, .i_end_burst(o_end_burst), .o_frame_start(i_frame_start),
      .o_burst_active(i_burst_active), .o_gnt_int(i_gnt_int), .o_evt(i_evt), .o_parity_resp_en(i_parity_resp_en));

   // free-running 125 MHz clock
   initial begin
      i_mclk = 1'b0;
      forever #4 i_mclk = ~i_mclk;
   end

   // hang guard, far above the few hundred cycles the tests need
   always @(posedge i_mclk) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         final_report();
      end
   end

   // ==========================================
   // access tasks: strobe up one falling edge, answer checked at the next
   task automatic cfg_wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge i_mclk);
      i_cfg_wr = 1'b1;
      i_cfg_addr = a;
      i_cfg_wdata = d;
      @(negedge i_mclk);
      i_cfg_wr = 1'b0;
   endtask : cfg_wr

   task automatic cfg_rd(input logic [7:0] a, input logic [7:0] e);
      @(negedge i_mclk);
      i_cfg_rd = 1'b1;
      i_cfg_addr = a;
      @(negedge i_mclk);
      i_cfg_rd = 1'b0;
      `CHK("rvalid", 1'b1, o_cfg_rvalid)
      `CHK("rdata", e, o_cfg_rdata)
   endtask : cfg_rd

   task automatic req(input logic [7:0] bus, input logic t1, input logic ma);
      @(negedge i_mclk);
      i_cfgreq_valid = 1'b1;
      i_cfgreq_bus = bus;
      @(negedge i_mclk);
      i_cfgreq_valid = 1'b0;
      `CHK("type1", t1, o_cfg_type1)
      `CHK("mabort", ma, o_cfg_mabort)
   endtask : req

   task automatic io(input logic [15:0] a, input logic hit);
      @(negedge i_mclk);
      i_io_valid = 1'b1;
      i_io_addr = a;
      @(negedge i_mclk);
      i_io_valid = 1'b0;
      `CHK("io_hit", hit, o_io_hit)
   endtask : io

   // grant already gone: the end must come exactly n*8+2 clocks after the frame edge
   task automatic tenure(input logic [4:0] n);
      cfg_wr(8'h1b, {n, 3'h0});
      hpb_pci_agent_i.start_burst(1'b0);
      repeat (int'(n) * 8 + 1) @(negedge i_mclk);
      `CHK("end_early", 1'b0, o_end_burst)
      @(negedge i_mclk);
      `CHK("end_burst", 1'b1, o_end_burst)
   endtask : tenure

   task automatic final_report;
      if (miscompares == 0 && checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : final_report

   // ==========================================
   // main sequence
   initial begin
      i_rst = 1'b1;
      {i_cfg_wr, i_cfg_rd, i_cfgreq_valid, i_io_valid} = '0;
      {i_cfg_addr, i_cfg_wdata, i_cfgreq_bus, i_io_addr} = '0;
      repeat (5) @(negedge i_mclk);
      i_rst = 1'b0;
      for (int i = 0; i < 7; i++) cfg_rd(wa[i], rst_exp[i]);
      for (int i = 0; i < 8; i++) begin
         cfg_wr(wa[i], 8'hff);
         cfg_rd(wa[i], wr_exp[i]);
      end
      // bus range 2..5, both edges of the range and just outside
      cfg_wr(8'h19, 8'h02);
      cfg_wr(8'h1a, 8'h05);
      req(8'h01, 1'b0, 1'b1);
      req(8'h02, 1'b1, 1'b0);
      req(8'h05, 1'b1, 1'b0);
      req(8'h06, 1'b0, 1'b1);
      cfg_wr(8'h19, 8'h00);
      cfg_wr(8'h1a, 8'h00);
      req(8'h00, 1'b1, 1'b0);
      req(8'h01, 1'b0, 1'b1);
      // window 3000h..5fffh
      cfg_wr(8'h1c, 8'h30);
      cfg_wr(8'h1d, 8'h50);
      io(16'h2fff, 1'b0);
      io(16'h3000, 1'b1);
      io(16'h5fff, 1'b1);
      io(16'h6000, 1'b0);
      // error flags: set, survive a zero write, clear on a one
      for (int i = 0; i < 4; i++) begin
         hpb_pci_agent_i.fire(ev[i], 1'b0);
         cfg_rd(8'h1f, 8'(ev[i]) | 8'h02);
         cfg_wr(8'h1f, 8'h00);
         cfg_rd(8'h1f, 8'(ev[i]) | 8'h02);
         cfg_wr(8'h1f, 8'(ev[i]));
         cfg_rd(8'h1f, 8'h02);
      end
      // an event and its clear in the same cycle: the event must win
      fork
         hpb_pci_agent_i.fire(hpb_err_evt_t'(8'h20), 1'b0);
         cfg_wr(8'h1f, 8'h20);
      join
      cfg_rd(8'h1f, 8'h22);
      hpb_pci_agent_i.fire(hpb_err_evt_t'(8'h18), 1'b0);
      `CHK("sta_set", 1'b1, o_upstream_sta_set)
      `CHK("tabort_hub", 1'b1, o_tabort_to_hub)
      cfg_wr(8'h1f, 8'h30);
      // parity fault flag is bit 8, lane 0 of the high status byte
      hpb_pci_agent_i.fire(hpb_err_evt_t'(8'h06), 1'b0);
      hpb_pci_agent_i.fire(hpb_err_evt_t'(8'h02), 1'b1);
      cfg_rd(8'h1f, 8'h02);
      hpb_pci_agent_i.fire(hpb_err_evt_t'(8'h05), 1'b1);
      cfg_rd(8'h1f, 8'h03);
      cfg_wr(8'h1e, 8'h01);
      cfg_rd(8'h1f, 8'h03);
      cfg_wr(8'h1f, 8'h01);
      cfg_rd(8'h1f, 8'h02);
      cfg_rd(8'h1e, 8'h80);
      // tenure at the smallest budget and a mid value
      tenure(5'h00);
      tenure(5'h03);
      // grant held past expiry keeps the bus until the grant goes
      cfg_wr(8'h1b, 8'h08);
      hpb_pci_agent_i.start_burst(1'b1);
      repeat (20) @(negedge i_mclk);
      `CHK("end_with_gnt", 1'b0, o_end_burst)
      hpb_pci_agent_i.set_gnt(1'b0);
      @(negedge i_mclk);
      `CHK("end_after_gnt", 1'b1, o_end_burst)
      repeat (2) @(negedge i_mclk);
      final_report();
   end
endmodule : tb_top
